// ==== design/rxs_map.svh ====
// Purpose: constants for the reset and exception entry sequencer
// Assumes: 10 MHz system clock, 16-bit address, byte-wide memory
// Notes: offsets, field positions, reset values and counts only
`ifndef RXS_MAP_SVH
`define RXS_MAP_SVH
`define RXS_RESET_VEC_HI 16'h0000
`define RXS_RESET_VEC_LO 16'h0001
`define RXS_MASK_BIT 7
`define RXS_FLAGS_RESET 8'h80
`define RXS_PC_RESET 16'h0000
`define RXS_MIN_RESET_CYCLES 4'h9
`endif

// ==== design/rxs_pkg.sv ====
// Purpose: types for the reset and exception entry sequencer
// Assumes: nothing beyond rxs_map.svh
// Notes: states and the bus request carrier
package rxs_pkg;
  typedef enum logic [2:0] {
    RXS_HOLD = 3'b000,
    RXS_INIT = 3'b001,
    RXS_VEC_HI = 3'b010,
    RXS_VEC_LO = 3'b011,
    RXS_FIRST = 3'b100,
    RXS_RUN = 3'b101,
    RXS_IRQ = 3'b110
  } rxs_state_t;
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } rxs_bus_req_t;
endpackage : rxs_pkg

// ==== design/rxs_pin_filter.sv ====
// Purpose: reset pin sampler with low-time counter
// Assumes: pin synchronous to clk
// Notes: counts consecutive low samples for status only
`timescale 1ns/1ps
`default_nettype none
`include "rxs_map.svh"
module rxs_pin_filter #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin
  input wire logic pin_n,
  // status
  output logic low_ff,
  output logic long_ff
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic nxt_long;
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_long = long_ff;
    if (pin_n) begin
      nxt_cnt = '0;
      nxt_long = 1'b0;
    end else if (cnt_ff != {CNT_W{1'b1}}) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    if (!pin_n && cnt_ff >= CNT_W'(`RXS_MIN_RESET_CYCLES)) begin
      nxt_long = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      long_ff <= 1'b0;
      low_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      long_ff <= nxt_long;
      low_ff <= !pin_n;
    end
  end
endmodule // rxs_pin_filter
`default_nettype wire

// ==== design/rxs_sequencer.sv ====
// Purpose: reset and interrupt entry sequencing for a small cpu
// Assumes: memory answers a read in the cycle after the request
// Notes: interrupt vector fetch is left to the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "rxs_map.svh"
module rxs_sequencer
  import rxs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // reset pin
  input wire logic chip_init_pin_n,
  // cpu side
  input wire logic insn_done,
  input wire logic irq_req,
  input wire logic mask_clear,
  input wire logic [7:0] mem_rdata,
  // outputs
  output rxs_bus_req_t bus_req_ff,
  output logic [ADDR_W-1:0] pc_ff,
  output logic pc_load_ff,
  output logic [7:0] condition_flags_word,
  output logic periph_init_ff,
  output logic run_ff,
  output logic irq_take_ff,
  output logic reset_long_ff
);
  rxs_state_t state_ff, nxt_state;
  rxs_bus_req_t nxt_bus_req;
  logic [ADDR_W-1:0] nxt_pc;
  logic nxt_pc_load;
  logic [7:0] flags_ff, nxt_flags;
  logic nxt_init, nxt_run, nxt_take;
  logic pin_low, pin_long;

  rxs_pin_filter #(.CNT_W(4)) u_pin (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_n(chip_init_pin_n),
    .low_ff(pin_low),
    .long_ff(pin_long)
  );

  assign condition_flags_word = flags_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_bus_req = '0;
    nxt_pc = pc_ff;
    nxt_pc_load = 1'b0;
    nxt_flags = flags_ff;
    nxt_init = 1'b0;
    nxt_run = 1'b0;
    nxt_take = 1'b0;
    if (!chip_init_pin_n) begin
      // pin low beats everything, including a pending interrupt
      nxt_state = RXS_HOLD;
      nxt_init = 1'b1;
      nxt_flags = `RXS_FLAGS_RESET;
      nxt_pc = ADDR_W'(`RXS_PC_RESET);
    end else begin
      case (state_ff)
        RXS_HOLD: begin
          nxt_state = RXS_INIT;
          nxt_init = 1'b1;
        end
        RXS_INIT: begin
          nxt_flags = `RXS_FLAGS_RESET;
          nxt_bus_req.rd = 1'b1;
          nxt_bus_req.addr = `RXS_RESET_VEC_HI;
          nxt_state = RXS_VEC_HI;
        end
        RXS_VEC_HI: begin
          // upper byte comes from the lower address
          nxt_pc = {mem_rdata, pc_ff[7:0]};
          nxt_bus_req.rd = 1'b1;
          nxt_bus_req.addr = `RXS_RESET_VEC_LO;
          nxt_state = RXS_VEC_LO;
        end
        RXS_VEC_LO: begin
          nxt_pc = {pc_ff[15:8], mem_rdata};
          nxt_pc_load = 1'b1;
          nxt_run = 1'b1;
          nxt_state = RXS_FIRST;
        end
        RXS_FIRST: begin
          // mask stays set; first instruction cannot be interrupted
          nxt_run = 1'b1;
          if (insn_done) begin
            nxt_state = RXS_RUN;
          end
        end
        RXS_RUN: begin
          nxt_run = 1'b1;
          if (mask_clear) begin
            nxt_flags[`RXS_MASK_BIT] = 1'b0;
          end
          // requests are only taken at an instruction boundary
          if (irq_req && insn_done && !flags_ff[`RXS_MASK_BIT]) begin
            nxt_take = 1'b1;
            nxt_flags[`RXS_MASK_BIT] = 1'b1;
            nxt_run = 1'b0;
            nxt_state = RXS_IRQ;
          end
        end
        RXS_IRQ: begin
          nxt_run = 1'b1;
          nxt_state = RXS_RUN;
        end
        default: nxt_state = RXS_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= RXS_HOLD;
      bus_req_ff <= '0;
      pc_ff <= '0;
      pc_load_ff <= 1'b0;
      flags_ff <= 8'h80;
      periph_init_ff <= 1'b1;
      run_ff <= 1'b0;
      irq_take_ff <= 1'b0;
      reset_long_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bus_req_ff <= nxt_bus_req;
      pc_ff <= nxt_pc;
      pc_load_ff <= nxt_pc_load;
      flags_ff <= nxt_flags;
      periph_init_ff <= nxt_init;
      run_ff <= nxt_run;
      irq_take_ff <= nxt_take;
      reset_long_ff <= pin_long | (reset_long_ff & pin_low);
    end
  end

  property p_pin_halts;
    @(posedge clk) disable iff (sys_rst)
    !chip_init_pin_n |=> (state_ff == RXS_HOLD) && !run_ff;
  endproperty
  AST_PIN_HALTS: assert property (p_pin_halts)
    else $error("reset pin low did not halt");

  sequence s_release;
    $rose(chip_init_pin_n) ##0 state_ff == RXS_HOLD;
  endsequence
  sequence s_fetch;
    ##1 state_ff == RXS_INIT ##1 bus_req_ff.rd &&
      bus_req_ff.addr == 16'h0000 ##1 bus_req_ff.rd &&
      bus_req_ff.addr == 16'h0001;
  endsequence
  sequence s_load;
    ##1 pc_load_ff && run_ff;
  endsequence
  // a pin that drops again mid-fetch restarts everything, so stop watching
  AST_RESET_START: assert property (@(posedge clk)
    disable iff (sys_rst || !chip_init_pin_n)
    s_release |-> s_fetch ##0 s_load)
    else $error("reset handling did not start on release");

  AST_PIN_INIT: assert property (@(posedge clk) disable iff (sys_rst)
    !chip_init_pin_n |=> periph_init_ff &&
      flags_ff == `RXS_FLAGS_RESET && pc_ff == ADDR_W'(`RXS_PC_RESET))
    else $error("reset pin low did not initialise state");

  // the second vector read is the last one; no stray reads follow it
  AST_REQ_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    bus_req_ff.rd && bus_req_ff.addr == 16'h0001 |=>
      !bus_req_ff.rd)
    else $error("vector read request held too long");

  AST_PC_HELD: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == RXS_RUN |=> !pc_load_ff)
    else $error("pc reloaded outside reset handling");

  AST_RUN_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == RXS_FIRST |-> run_ff &&
      flags_ff[`RXS_MASK_BIT])
    else $error("first instruction not running masked");

  // only software may open the mask; nothing else clears it
  AST_MASK_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    flags_ff[`RXS_MASK_BIT] && !mask_clear |=>
      flags_ff[`RXS_MASK_BIT])
    else $error("mask bit dropped without software clear");

  AST_TAKE_MASKS: assert property (@(posedge clk) disable iff (sys_rst)
    irq_take_ff |-> flags_ff[`RXS_MASK_BIT] && !run_ff)
    else $error("interrupt entry left mask open or kept running");

  AST_LONG_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    chip_init_pin_n && $past(chip_init_pin_n) |=>
      !reset_long_ff)
    else $error("long reset status kept after release");

  AST_MASK_SET: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == RXS_INIT |=> flags_ff[7])
    else $error("mask bit not set by reset handling");

  AST_PC_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == RXS_VEC_LO && chip_init_pin_n |=>
      pc_load_ff && pc_ff[7:0] == $past(mem_rdata))
    else $error("pc low byte not from vector");

  AST_HI_BYTE: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == RXS_VEC_HI && chip_init_pin_n |=>
      pc_ff[15:8] == $past(mem_rdata))
    else $error("pc high byte not from lower address");

  AST_NO_IRQ_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff inside {RXS_HOLD, RXS_INIT, RXS_VEC_HI, RXS_VEC_LO,
      RXS_FIRST} |=> !irq_take_ff)
    else $error("interrupt taken during reset or first instruction");

  AST_MASKED: assert property (@(posedge clk) disable iff (sys_rst)
    flags_ff[7] |=> !irq_take_ff)
    else $error("interrupt taken while masked");

  AST_BOUNDARY: assert property (@(posedge clk) disable iff (sys_rst)
    irq_take_ff |-> $past(insn_done) && $past(irq_req))
    else $error("interrupt taken off an instruction boundary");
endmodule // rxs_sequencer
`default_nettype wire

// ==== bench/rxs_reset_source.sv ====
// Purpose: outside reset circuit driving the active-low reset pin
// Assumes: changes the pin on the falling clock edge
// Notes: never releases before MIN_LOW low cycles have passed
`timescale 1ns/1ps
`default_nettype none
module rxs_reset_source #(
  parameter int MIN_LOW = 10
) (
  // clock
  input wire logic clk,
  // control
  input wire logic power_ok,
  input wire logic want_reset,
  // pin
  output logic chip_init_pin_n
);
  int cnt = 0;
  initial chip_init_pin_n = 1'b0;
  always @(negedge clk) begin
    // low through power-up and while power is unstable
    if (!power_ok || want_reset ||
        (!chip_init_pin_n && cnt < MIN_LOW)) begin
      chip_init_pin_n <= 1'b0;
      cnt <= chip_init_pin_n ? 1 : cnt + 1;
    end else begin
      chip_init_pin_n <= 1'b1;
    end
  end
endmodule // rxs_reset_source
`default_nettype wire

// ==== bench/rxs_sequencer_bench.sv ====
// Purpose: self-checking bench for the reset and exception sequencer
// Assumes: memory answers in the cycle after a read request
// Notes: three reset rounds with random vectors (low byte ff in the first) and interrupt traffic
`timescale 1ns/1ps
`default_nettype none
module rxs_sequencer_bench;
  import rxs_pkg::*;
  logic clk = 0, sys_rst = 1, power_ok = 0, want_reset = 0, pin_n;
  logic insn_done = 0, irq_req = 0, mask_clear = 0;
  logic [7:0] mem_rdata = 8'h00, vhi, vlo, flags;
  logic [15:0] pc;
  logic pc_load, periph_init, run, irq_take, reset_long;
  rxs_bus_req_t bus_req;
  logic [15:0] addr_q[$];
  int seed = 52336, miscompares = 0, total_checks = 0, n;
  always #50 clk = ~clk;
  rxs_reset_source i_rxs_reset_source (.clk(clk), .power_ok(power_ok),
    .want_reset(want_reset), .chip_init_pin_n(pin_n));
  rxs_sequencer i_rxs_sequencer (.clk(clk), .sys_rst(sys_rst),
    .chip_init_pin_n(pin_n), .insn_done(insn_done), .irq_req(irq_req),
    .mask_clear(mask_clear), .mem_rdata(mem_rdata), .bus_req_ff(bus_req),
    .pc_ff(pc), .pc_load_ff(pc_load), .condition_flags_word(flags),
    .periph_init_ff(periph_init), .run_ff(run), .irq_take_ff(irq_take),
    .reset_long_ff(reset_long));
  // memory: vector bytes on request, noise otherwise
  always @(negedge clk) begin
    if (bus_req.rd === 1'b1) begin
      addr_q.push_back(bus_req.addr);
      mem_rdata = bus_req.addr[0] ? vlo : vhi;
    end else begin
      mem_rdata = $random(seed);
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask
  initial begin
    step(12);
    sys_rst = 0;
    step(3);
    for (int i = 0; i < 3; i++) begin
      vhi = $random(seed);
      vlo = (i == 0) ? 8'hff : $random(seed);
      addr_q.delete();
      power_ok <= 1'b1;
      want_reset <= 1'b0;
      for (n = 0; n < 10 && pc_load !== 1'b1; n++) step(1);
      chk(pc_load, 1);
      chk(pc, {vhi, vlo});
      chk(addr_q.size(), 2);
      chk(addr_q[0], 16'h0000);
      chk(addr_q[1], 16'h0001);
      chk(flags[7], 1);
      chk(run, 1);
      irq_req = 1;
      insn_done = 1;
      step(1);
      insn_done = 0;
      for (n = 0; n < 4; n++) begin
        step(1);
        chk(irq_take, 0);
      end
      mask_clear = 1;
      step(1);
      mask_clear = 0;
      for (n = 0; n < 1 + ($random(seed) & 3); n++) begin
        step(1);
        chk(irq_take, 0);
      end
      chk(flags[7], 0);
      insn_done = 1;
      step(1);
      insn_done = 0;
      for (n = 0; n < 3 && irq_take !== 1'b1; n++) step(1);
      chk(irq_take, 1);
      step(1);
      chk(flags[7], 1);
      want_reset <= 1'b1;
      step(2);
      chk(run, 0);
      chk(periph_init, 1);
      step(2);
      chk(reset_long, 0);
      for (n = 0; n < 10; n++) begin
        insn_done = $random(seed);
        step(1);
        chk(irq_take, 0);
      end
      chk(reset_long, 1);
      chk(flags, 8'h80);
      insn_done = 0;
      irq_req = 0;
    end
    complete_run();
  end
  initial begin
    step(3000);
    miscompares++;
    complete_run();
  end
endmodule // rxs_sequencer_bench
`default_nettype wire
